/* File: bench/tcg_dev_model.sv */
// tcg_dev_model: behavioural timer/carrier device seen by the host
`timescale 1ns/10ps
module tcg_dev_model import tcg_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// device bus
	input wire logic [15:0] dev_addr,
	input wire logic [7:0] dev_wdata,
	input wire logic dev_wr,
	input wire logic dev_rd,
	output logic [7:0] dev_rdata,
	// interrupt and pin
	input wire logic irq_hold,
	output logic dev_match_irq_a,
	output logic tb_out_pin
);
	logic [7:0] p3_r, car_r, mode_a_r, mode_b_r, cmp_a_r, cmp_b_r, cnt_a_r, rd_r;
	logic match_a, tog_r;
	logic [7:0] cnt_b_r;
	assign match_a = mode_a_r[MODE_RUN_BIT] && cnt_a_r == cmp_a_r;
	assign dev_match_irq_a = match_a || irq_hold;
	assign dev_rdata = rd_r;
	// toggling stand-in for the carrier clock, steady level when selected
	assign tb_out_pin = mode_b_r[0] && car_r[0] && (car_r[2] || tog_r);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			p3_r <= PORT3_DIR_RST;
			car_r <= CARRIER_CTRL_RST;
			mode_a_r <= 8'h00;
			mode_b_r <= 8'h00;
			cmp_a_r <= 8'h00;
			cmp_b_r <= 8'h00;
		end else begin
			if (dev_wr && dev_addr == DEV_PORT3_DIR) p3_r <= dev_wdata | 8'hF0;
			if (dev_wr && dev_addr == DEV_TIMER_A_MODE) mode_a_r <= dev_wdata;
			if (dev_wr && dev_addr == DEV_TIMER_B_MODE) mode_b_r <= dev_wdata;
			if (dev_wr && dev_addr == DEV_TIMER_A_COMPARE) cmp_a_r <= dev_wdata;
			if (dev_wr && dev_addr == DEV_TIMER_B_COMPARE) cmp_b_r <= dev_wdata;
			if (dev_wr && dev_addr == DEV_CARRIER_CTRL) begin
				car_r[2:1] <= dev_wdata[2:1];
				if (!mode_b_r[0]) car_r[0] <= dev_wdata[0];
			end else if (match_a) car_r[0] <= car_r[1];
			if (dev_wr && dev_addr == DEV_TIMER_B_MODE && !dev_wdata[0]) car_r[1] <= 1'b0;
		end
	end
	// counter A runs on the bus clock; a cleared run bit or a match clears it
	always_ff @(posedge clk) begin
		tog_r <= rst_n && !tog_r;
		if (!rst_n || !mode_a_r[MODE_RUN_BIT] || match_a) cnt_a_r <= 8'h00;
		else cnt_a_r <= cnt_a_r + 8'h01;
		// counter B takes one count per rising edge of the toggle
		if (!rst_n || !mode_b_r[MODE_RUN_BIT]) cnt_b_r <= 8'h00;
		else if (cnt_b_r == cmp_b_r) cnt_b_r <= 8'h00;
		else if (tog_r) cnt_b_r <= cnt_b_r + 8'h01;
		// outside its answer cycle the bus shows no stale byte; write-only reads back junk
		if (dev_rd && dev_addr == DEV_TIMER_A_COUNTER) rd_r <= cnt_a_r;
		else if (dev_rd && dev_addr == DEV_PORT3_DIR) rd_r <= p3_r;
		else rd_r <= ~rd_r;
	end
endmodule : tcg_dev_model

/* File: bench/tcg_host_ctrl_asserts.sv */
// tcg_chk: port checker for the timer/carrier host
`timescale 1ns/10ps
module tcg_chk import tcg_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// software port
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// device side
	input wire logic [15:0] dev_addr,
	input wire logic [7:0] dev_wdata,
	input wire logic dev_wr,
	input wire logic dev_rd,
	input wire logic dev_match_irq_a
);
	logic [7:0] last_a_r, last_b_r, last_p3_r;
	logic cnt_rd_r;
	logic car_wr, a_wr, b_wr;
	// ------------------
	// last bytes written
	// ------------------
	assign car_wr = dev_wr && dev_addr == DEV_CARRIER_CTRL;
	assign a_wr = dev_wr && dev_addr == DEV_TIMER_A_MODE;
	assign b_wr = dev_wr && dev_addr == DEV_TIMER_B_MODE;
	// a start is judged against the previous byte, so a skipped stop shows
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			last_a_r <= 8'h00;
			last_b_r <= 8'h00;
			last_p3_r <= 8'hFF;
		end else begin
			if (a_wr) last_a_r <= dev_wdata;
			if (b_wr) last_b_r <= dev_wdata;
			if (dev_wr && dev_addr == DEV_PORT3_DIR) last_p3_r <= dev_wdata;
		end
	end
	// counter A must be looked at before every carrier write
	always_ff @(posedge clk) begin
		if (!rst_n || car_wr) cnt_rd_r <= 1'b0;
		else if (dev_rd && dev_addr == DEV_TIMER_A_COUNTER) cnt_rd_r <= 1'b1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_RESET_QUIET: assert property ($rose(rst_n) |-> !dev_wr && !dev_rd && reg_rdata == 8'h00)
		else $error("outputs busy at reset release");
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	AST_STROBE_EXCL: assert property (!(dev_wr && dev_rd))
		else $error("device read and write together");
	AST_CAR_HIGH_ZERO: assert property (car_wr |-> dev_wdata[7:3] == 5'h00)
		else $error("carrier byte upper bits set");
	AST_CAR_IRQ_HELD: assert property (dev_match_irq_a [*6] |-> !car_wr)
		else $error("carrier write during match interrupt");
	AST_CAR_AFTER_CNT: assert property (car_wr |-> cnt_rd_r)
		else $error("carrier write without counter check");
	AST_A_START: assert property (a_wr && dev_wdata[7] |-> !last_a_r[7] &&
		last_a_r[5:0] == dev_wdata[5:0]) else $error("timer A started unprepared");
	AST_B_START: assert property (b_wr && dev_wdata[7] |-> !last_b_r[7] &&
		last_b_r[5:0] == dev_wdata[5:0]) else $error("timer B started unprepared");
	AST_B_PIN_OUT: assert property (b_wr && dev_wdata[0] |-> !last_p3_r[PIN_TB_OUT])
		else $error("timer B output enabled on input pin");
	AST_EVENT_PIN_IN: assert property (b_wr && dev_wdata[7] && dev_wdata[5:3] >= CLK_B_EXT_MIN
		|-> last_p3_r[PIN_EVENT_IN]) else $error("event clock with pin not input");
endmodule : tcg_chk
bind tcg_host_ctrl tcg_chk i_chk (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
	.dev_rd(dev_rd), .dev_match_irq_a(dev_match_irq_a));

/* File: bench/test_tcg_host_ctrl.sv */
// test_tcg_host_ctrl: self-checking bench for the timer/carrier host
`timescale 1ns/10ps
module test_tcg_host_ctrl import tcg_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic irq_hold = 1'b0;
	logic rd_seen = 1'b0;
	logic [7:0] reg_rdata, dev_wdata, dev_rdata, rd_got, v;
	logic [15:0] dev_addr, e;
	logic dev_wr, dev_rd, irq_a, pin;
	logic [15:0] expq[$];
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed = 32'h4439;
	int i;
	always #10 clk = ~clk;
	tcg_host_ctrl i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
		.dev_match_irq_a(irq_a));
	tcg_dev_model i_dev (.clk(clk), .rst_n(rst_n), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
		.dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata), .irq_hold(irq_hold),
		.dev_match_irq_a(irq_a), .tb_out_pin(pin));
	task automatic summarize();
		if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
		n_checks++;
		if ((got & m) !== (exp & m)) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_reg
	task automatic cmp_dev(input logic [7:0] got, input logic [7:0] exp);
		cmp_reg(got, exp, 8'hFF);
	endtask : cmp_dev
	// each strobe is followed by an idle edge so no signal is driven twice at once
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
		expq.push_back({exp, m});
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		rd_got = reg_rdata;
		@(posedge clk);
	endtask : rd
	// poll busy under a bound; the poll itself checks nothing
	task automatic cmd(input logic [3:0] op);
		wr(REG_CMD, {4'h0, op});
		for (int k = 0; k < 200; k++) begin
			rd(REG_STATUS, 8'h00, 8'h00);
			if (rd_got[ST_BUSY] === 1'b0) break;
		end
	endtask : cmd
	// read data is checked mid-cycle, while it stands
	always @(negedge clk) begin
		if (rd_seen) begin
			e = expq.pop_front();
			cmp_reg(reg_rdata, e[15:8], e[7:0]);
		end
		rd_seen <= reg_rd;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(REG_PORT3, 8'hFF, 8'hFF);
		cmp_dev(i_dev.car_r, 8'h00);
		rd(4'hF, 8'h00, 8'hFF);
		wr(REG_GUARD_LO, 8'h02);
		wr(REG_GUARD_HI, 8'h00);
		wr(REG_CLK_B, 8'h02);
		cmd(OP_EVENT_B);
		cmp_dev(i_dev.p3_r & 8'h02, 8'h02);
		cmp_dev(i_dev.mode_b_r, 8'h90);
		for (i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			wr(REG_CLK_A, 8'(i));
			wr(REG_CLK_B, 8'(i));
			wr(REG_CMP_A, v);
			wr(REG_CMP_B, ~v);
			cmd(OP_INTERVAL_A);
			cmd(OP_INTERVAL_B);
			cmp_dev(i_dev.mode_a_r, 8'h80 | 8'(i << 3));
			cmp_dev(i_dev.mode_b_r, 8'h80 | 8'(i << 3));
			cmp_dev(i_dev.cmp_a_r ^ ~i_dev.cmp_b_r, v ^ v);
		end
		wr(REG_CLK_A, 8'h06);
		cmd(OP_INTERVAL_A);
		rd(REG_STATUS, 8'h02, 8'h02);
		wr(REG_STATUS, 8'h06);
		wr(REG_CLK_A, 8'h00);
		wr(REG_CLK_B, 8'h01);
		cmd(OP_EVENT_B);
		rd(REG_STATUS, 8'h02, 8'h06);
		wr(REG_STATUS, 8'h06);
		wr(REG_CMD, {4'h0, OP_INTERVAL_A});
		cmd(OP_STOP_B);
		rd(REG_STATUS, 8'h04, 8'h06);
		// carrier: next 1 at steady level, current 0 until the first match
		wr(REG_STATUS, 8'h06);
		wr(REG_CLK_B, 8'h00);
		wr(REG_CMP_A, 8'h30);
		wr(REG_CARRIER, 8'h06);
		cmd(OP_CARRIER_START);
		cmp_dev(i_dev.car_r, 8'h06);
		cmp_dev(i_dev.p3_r & 8'h04, 8'h00);
		cmp_dev(i_dev.mode_b_r, 8'h87);
		repeat (60) @(posedge clk);
		cmp_dev({7'h00, pin}, 8'h01);
		// a held interrupt must keep the next write off the device
		wr(REG_CARRIER, 8'h02);
		irq_hold <= 1'b1;
		wr(REG_CMD, {4'h0, OP_CARRIER_NEXT});
		repeat (30) @(posedge clk);
		rd(REG_STATUS, 8'h19, 8'h19);
		cmp_dev(i_dev.car_r, 8'h07);
		irq_hold <= 1'b0;
		repeat (20) @(posedge clk);
		cmp_dev(i_dev.car_r, 8'h03);
		cmd(OP_CARRIER_STOP);
		cmp_dev(i_dev.car_r & 8'h06, 8'h00);
		rd(REG_STATUS, 8'h20, 8'h28);
		cmp_dev(i_dev.mode_a_r | i_dev.mode_b_r, 8'h00);
		cmd(OP_CARRIER_NEXT);
		rd(REG_STATUS, 8'h22, 8'h22);
		summarize();
	end
endmodule : test_tcg_host_ctrl

/* File: hw/tcg_dev_port.sv */
// tcg_dev_port: byte-wide register bus master toward the device
`timescale 1ns/10ps
module tcg_dev_port import tcg_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request from sequencer, answer back
	input wire tcg_dev_req_t req,
	output logic rd_valid,
	output logic [7:0] rd_data,
	// device bus pins
	output logic [15:0] dev_addr,
	output logic [7:0] dev_wdata,
	output logic dev_wr,
	output logic dev_rd,
	input wire logic [7:0] dev_rdata
);

	logic [RD_LAT-1:0] pend_r;
	logic [7:0] rdata_s;

	// every access is a whole byte; no read-modify-write ever reaches the pins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dev_addr <= 16'h0000;
			dev_wdata <= 8'h00;
			dev_wr <= 1'b0;
			dev_rd <= 1'b0;
		end else begin
			dev_wr <= req.wr;
			dev_rd <= req.rd;
			if (req.wr || req.rd) begin
				dev_addr <= req.addr;
				dev_wdata <= req.data;
			end
		end
	end

	// read data crosses in from the pins, so it is timed against the synchroniser
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pend_r <= '0;
		end else begin
			pend_r <= {pend_r[RD_LAT-2:0], dev_rd};
		end
	end

	tcg_sync2 #(.W(8)) u_rdata_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(dev_rdata),
		.q(rdata_s)
	);

	assign rd_valid = pend_r[RD_LAT-1];
	assign rd_data = rdata_s;

endmodule : tcg_dev_port

/* File: hw/tcg_host_ctrl.sv */
// tcg_host_ctrl: host sequencer that sets up the dual timer and carrier generator
// Function
// RULE_01: carrier control register write-only, resets 00H
// RULE_02: next bit and level select shape output
// RULE_03: timer A match copies next into current
// RULE_04: current bit zero drives low, stops carrier
// RULE_05: current bit writable only with output disabled
// RULE_06: rewrite next bit by byte after restart
// RULE_07: write zero into carrier bits 3 to 7
// RULE_08: carrier register written only as byte
// RULE_09: no carrier access during timer A interrupt
// RULE_10: counter A at zero: wait half period
// RULE_11: load compares and carrier bits before enabling
// RULE_12: port 3 direction resets FFH, zero outputs
// RULE_13: timer pin output: clear direction and latch
// RULE_14: interval match clears counter, raises interrupt
// RULE_15: interval setup follows fixed six-step order; the interval sequence here issues five writes
// RULE_16: timer A clock select codes 000 to 101
// RULE_17: timer B clock select codes 000 to 101
// RULE_18: stop timer before changing its clock
// RULE_19: event mode counts each valid input edge
// RULE_20: event match clears counter, raises interrupt
// RULE_21: event pin set to input before start
// RULE_22: clearing run bit stops and zeroes counter
// RULE_23: 8-bit mode counts rising edges only
// RULE_24: carrier signal drives timer B output pin
`timescale 1ns/10ps
module tcg_host_ctrl import tcg_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// software register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// device register bus
	output logic [15:0] dev_addr,
	output logic [7:0] dev_wdata,
	output logic dev_wr,
	output logic dev_rd,
	input wire logic [7:0] dev_rdata,
	// device timer A match interrupt
	input wire logic dev_match_irq_a
);

	// --------------------
	// declarations
	// --------------------
	typedef enum logic [2:0] {
		S_IDLE, S_ISSUE, S_IRQ_WAIT, S_CNT_WAIT, S_HALF_WAIT, S_GUARD_WR
	} tcg_state_t;

	tcg_state_t state_r;
	logic [3:0] op_r;
	logic [3:0] idx_r;
	logic [2:0] clk_a_r;
	logic [2:0] clk_b_r;
	logic [7:0] cmp_a_r;
	logic [7:0] cmp_b_r;
	logic [7:0] cmp_bh_r;
	logic [2:0] carrier_r;
	logic [15:0] guard_r;
	logic [15:0] wait_r;
	logic [7:0] port3_r;
	logic cfg_err_r;
	logic overrun_r;
	logic carrier_on_r;
	logic rewrite_r;
	logic irq_s;
	logic rd_valid;
	logic [7:0] rd_data;
	tcg_step_t step;
	tcg_dev_req_t req;
	logic start_ok;
	logic cmd_wr;
	logic cfg_bad;
	logic [7:0] carrier_byte;

	// --------------------
	// helpers
	// --------------------
	function automatic logic [7:0] mode_byte(input logic run, input logic [2:0] cs,
		input logic [1:0] md, input logic oe);
		logic [7:0] b;
		b = 8'h00;
		b[MODE_RUN_BIT] = run;
		b[MODE_CLK_LSB +: 3] = cs;
		b[MODE_SEL_LSB +: 2] = md;
		b[MODE_OE_BIT] = oe;
		return b;
	endfunction : mode_byte

	function automatic tcg_step_t mk(input tcg_step_kind_t k, input logic [15:0] a,
		input logic [7:0] d);
		tcg_step_t s;
		s.kind = k;
		s.addr = a;
		s.data = d;
		return s;
	endfunction : mk

	// upper five bits always zero, whole byte every time
	always_comb begin
		carrier_byte = CARRIER_CTRL_RST; // RULE_07
		carrier_byte[CAR_CUR_BIT] = carrier_r[CAR_CUR_BIT];
		carrier_byte[CAR_NEXT_BIT] = carrier_r[CAR_NEXT_BIT];
		carrier_byte[CAR_LEVEL_BIT] = carrier_r[CAR_LEVEL_BIT];
	end

	// --------------------
	// sequence table: one device access per step
	// --------------------
	always_comb begin
		step = mk(STEP_END, 16'h0000, 8'h00);
		case (op_r)
			OP_STOP_A: begin
				if (idx_r == 4'h0) step = mk(STEP_WR, DEV_TIMER_A_MODE, MODE_STOPPED);
			end
			OP_STOP_B, OP_CARRIER_STOP: begin
				// stopping drops the next bit inside the device
				case (idx_r)
					4'h0: step = mk(STEP_WR, DEV_TIMER_B_MODE, MODE_STOPPED);
					4'h1: step = mk(STEP_WR, DEV_TIMER_A_MODE, MODE_STOPPED);
					default: step = mk(STEP_END, 16'h0000, 8'h00);
				endcase
				if (op_r == OP_STOP_B && idx_r != 4'h0) step = mk(STEP_END, 16'h0000, 8'h00);
			end
			OP_INTERVAL_A, OP_INTERVAL_B: begin
				// stop and disable, compare, mode, clock, start
				case (idx_r)
					4'h0: step = mk(STEP_WR, DEV_TIMER_A_MODE, MODE_STOPPED); // RULE_15
					4'h1: step = mk(STEP_WR, DEV_TIMER_A_COMPARE, cmp_a_r);
					4'h2: step = mk(STEP_WR, DEV_TIMER_A_MODE,
						mode_byte(1'b0, 3'h0, MODE_DISCRETE, 1'b0));
					4'h3: step = mk(STEP_WR, DEV_TIMER_A_MODE,
						mode_byte(1'b0, clk_a_r, MODE_DISCRETE, 1'b0)); // RULE_18
					4'h4: step = mk(STEP_WR, DEV_TIMER_A_MODE,
						mode_byte(1'b1, clk_a_r, MODE_DISCRETE, 1'b0));
					default: step = mk(STEP_END, 16'h0000, 8'h00);
				endcase
				if (op_r == OP_INTERVAL_B) begin
					case (idx_r)
						4'h1: step.data = cmp_b_r;
						4'h3: step.data = mode_byte(1'b0, clk_b_r, MODE_DISCRETE, 1'b0);
						4'h4: step.data = mode_byte(1'b1, clk_b_r, MODE_DISCRETE, 1'b0);
						default: step.data = step.data;
					endcase
					if (step.addr == DEV_TIMER_A_MODE) step.addr = DEV_TIMER_B_MODE;
					if (step.addr == DEV_TIMER_A_COMPARE) step.addr = DEV_TIMER_B_COMPARE;
				end
			end
			OP_EVENT_B: begin
				// event pin becomes an input before the external clock is chosen
				case (idx_r)
					4'h0: step = mk(STEP_WR, DEV_TIMER_B_MODE, MODE_STOPPED);
					4'h1: step = mk(STEP_WR, DEV_PORT3_DIR,
						port3_r | (8'h01 << PIN_EVENT_IN)); // RULE_21
					4'h2: step = mk(STEP_WR, DEV_TIMER_B_MODE,
						mode_byte(1'b0, clk_b_r, MODE_DISCRETE, 1'b0)); // RULE_18
					4'h3: step = mk(STEP_WR, DEV_TIMER_B_MODE,
						mode_byte(1'b0, clk_b_r, MODE_DISCRETE, 1'b0));
					4'h4: step = mk(STEP_WR, DEV_TIMER_B_COMPARE, cmp_b_r);
					4'h5: step = mk(STEP_WR, DEV_TIMER_B_MODE,
						mode_byte(1'b1, clk_b_r, MODE_DISCRETE, 1'b0));
					default: step = mk(STEP_END, 16'h0000, 8'h00);
				endcase
			end
			OP_CARRIER_START: begin
				// compares and all three carrier bits are loaded before the mode is enabled
				case (idx_r)
					4'h0: step = mk(STEP_WR, DEV_TIMER_A_MODE, MODE_STOPPED);
					4'h1: step = mk(STEP_WR, DEV_TIMER_B_MODE, MODE_STOPPED);
					4'h2: step = mk(STEP_WR, DEV_TIMER_A_COMPARE, cmp_a_r); // RULE_11
					4'h3: step = mk(STEP_WR, DEV_TIMER_B_COMPARE, cmp_b_r);
					4'h4: step = mk(STEP_WR, DEV_TIMER_B_HIGH_COMPARE, cmp_bh_r);
					4'h5: step = mk(STEP_WR, DEV_PORT3_LATCH, PORT3_LATCH_CLEAR); // RULE_13
					4'h6: step = mk(STEP_WR, DEV_PORT3_DIR,
						port3_r & ~(8'h01 << PIN_TB_OUT)); // RULE_13
					4'h7: step = mk(STEP_WR_GUARD, DEV_CARRIER_CTRL, carrier_byte); // RULE_11
					4'h8: step = mk(STEP_WR, DEV_TIMER_A_MODE,
						mode_byte(1'b0, clk_a_r, MODE_DISCRETE, 1'b0));
					4'h9: step = mk(STEP_WR, DEV_TIMER_B_MODE,
						mode_byte(1'b0, clk_b_r, MODE_B_CARRIER, 1'b1));
					4'hA: step = mk(STEP_WR, DEV_TIMER_B_MODE,
						mode_byte(1'b1, clk_b_r, MODE_B_CARRIER, 1'b1));
					4'hB: step = mk(STEP_WR, DEV_TIMER_A_MODE,
						mode_byte(1'b1, clk_a_r, MODE_DISCRETE, 1'b0));
					default: step = mk(STEP_END, 16'h0000, 8'h00);
				endcase
			end
			OP_CARRIER_NEXT: begin
				// full byte; the device ignores the current bit while output is on
				if (idx_r == 4'h0) step = mk(STEP_WR_GUARD, DEV_CARRIER_CTRL, carrier_byte); // RULE_08
			end
			default: step = mk(STEP_END, 16'h0000, 8'h00);
		endcase
	end

	// --------------------
	// command acceptance
	// --------------------
	assign cmd_wr = reg_wr && (reg_addr == REG_CMD);
	always_comb begin
		cfg_bad = (clk_a_r > CLK_SEL_MAX) || (clk_b_r > CLK_SEL_MAX); // RULE_16 RULE_17
		if (reg_wdata[3:0] == OP_EVENT_B && clk_b_r < CLK_B_EXT_MIN) cfg_bad = 1'b1;
		if (reg_wdata[3:0] == OP_CARRIER_NEXT && !carrier_on_r) cfg_bad = 1'b1;
		if (reg_wdata[3:0] == 4'h0 || reg_wdata[3:0] > OP_CARRIER_STOP) cfg_bad = 1'b1;
	end
	assign start_ok = cmd_wr && (state_r == S_IDLE) && !cfg_bad;

	// --------------------
	// sequencer state machine
	// --------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= S_IDLE;
			op_r <= 4'h0;
			idx_r <= 4'h0;
			wait_r <= 16'h0000;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (start_ok) begin
						op_r <= reg_wdata[3:0];
						idx_r <= 4'h0;
						state_r <= S_ISSUE;
					end
				end
				S_ISSUE: begin
					case (step.kind)
						STEP_WR: idx_r <= idx_r + 4'h1;
						STEP_WR_GUARD: state_r <= S_IRQ_WAIT;
						default: state_r <= S_IDLE;
					endcase
				end
				S_IRQ_WAIT: begin
					// counter is read only once the match interrupt has dropped
					if (!irq_s) state_r <= S_CNT_WAIT; // RULE_09
				end
				S_CNT_WAIT: begin
					if (rd_valid) begin
						if (rd_data == 8'h00) begin
							wait_r <= guard_r;
							state_r <= S_HALF_WAIT; // RULE_10
						end else begin
							state_r <= S_GUARD_WR;
						end
					end
				end
				S_HALF_WAIT: begin
					// zero-length guard still waits one cycle
					if (wait_r <= 16'h0001) state_r <= S_GUARD_WR; // RULE_10
					else wait_r <= wait_r - 16'h0001;
				end
				S_GUARD_WR: begin
					if (irq_s) begin
						state_r <= S_IRQ_WAIT; // RULE_09
					end else begin
						idx_r <= idx_r + 4'h1;
						state_r <= S_ISSUE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// device requests: writes from the table, the counter read, the guarded write
	always_comb begin
		req = '0;
		req.addr = step.addr;
		req.data = step.data;
		if (state_r == S_ISSUE && step.kind == STEP_WR) req.wr = 1'b1;
		if (state_r == S_IRQ_WAIT && !irq_s) begin
			req.rd = 1'b1;
			req.addr = DEV_TIMER_A_COUNTER;
		end
		if (state_r == S_GUARD_WR && !irq_s) req.wr = 1'b1;
	end

	// --------------------
	// software registers
	// --------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clk_a_r <= 3'h0;
			clk_b_r <= 3'h0;
			cmp_a_r <= 8'h00;
			cmp_b_r <= 8'h00;
			cmp_bh_r <= 8'h00;
			carrier_r <= 3'h0;
			guard_r <= GUARD_WAIT_CYC;
		end else if (reg_wr) begin
			case (reg_addr)
				REG_CLK_A: clk_a_r <= reg_wdata[2:0];
				REG_CLK_B: clk_b_r <= reg_wdata[2:0];
				REG_CMP_A: cmp_a_r <= reg_wdata;
				REG_CMP_B: cmp_b_r <= reg_wdata;
				REG_CMP_BH: cmp_bh_r <= reg_wdata;
				REG_CARRIER: carrier_r <= reg_wdata[2:0];
				REG_GUARD_LO: guard_r[7:0] <= reg_wdata;
				REG_GUARD_HI: guard_r[15:8] <= reg_wdata;
				default: guard_r <= guard_r;
			endcase
		end
	end

	// shadow of the device direction register, which starts as all inputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port3_r <= PORT3_DIR_RST; // RULE_12
		end else if (req.wr && req.addr == DEV_PORT3_DIR) begin
			port3_r <= req.data;
		end
	end

	// carrier run state and the rewrite-needed flag after a restart
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			carrier_on_r <= 1'b0;
			rewrite_r <= 1'b0;
		end else if (start_ok) begin
			case (reg_wdata[3:0])
				OP_CARRIER_START: begin
					carrier_on_r <= 1'b1;
					rewrite_r <= 1'b0;
				end
				OP_CARRIER_STOP, OP_STOP_A, OP_STOP_B: begin
					// device has lost the next bit; software must send it again
					rewrite_r <= carrier_on_r; // RULE_06
					carrier_on_r <= 1'b0;
				end
				OP_CARRIER_NEXT: rewrite_r <= 1'b0; // RULE_06
				default: carrier_on_r <= carrier_on_r;
			endcase
		end
	end

	// error flags: write one to clear, a new error wins over the clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_err_r <= 1'b0;
			overrun_r <= 1'b0;
		end else begin
			if (cmd_wr && state_r == S_IDLE && cfg_bad) cfg_err_r <= 1'b1;
			else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_CFG_ERR]) cfg_err_r <= 1'b0;
			if (cmd_wr && state_r != S_IDLE) overrun_r <= 1'b1;
			else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_OVERRUN]) overrun_r <= 1'b0;
		end
	end

	// read data in the cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CMD: reg_rdata <= {4'h0, op_r};
				REG_CLK_A: reg_rdata <= {5'h00, clk_a_r};
				REG_CLK_B: reg_rdata <= {5'h00, clk_b_r};
				REG_CMP_A: reg_rdata <= cmp_a_r;
				REG_CMP_B: reg_rdata <= cmp_b_r;
				REG_CMP_BH: reg_rdata <= cmp_bh_r;
				REG_CARRIER: reg_rdata <= {5'h00, carrier_r};
				REG_STATUS: reg_rdata <= {2'h0, rewrite_r, irq_s, carrier_on_r, overrun_r,
					cfg_err_r, state_r != S_IDLE};
				REG_GUARD_LO: reg_rdata <= guard_r[7:0];
				REG_GUARD_HI: reg_rdata <= guard_r[15:8];
				REG_PORT3: reg_rdata <= port3_r;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// --------------------
	// pin-side blocks
	// --------------------
	tcg_sync2 #(.W(1)) u_irq_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(dev_match_irq_a),
		.q(irq_s)
	);

	tcg_dev_port u_dev_port (
		.clk(clk),
		.rst_n(rst_n),
		.req(req),
		.rd_valid(rd_valid),
		.rd_data(rd_data),
		.dev_addr(dev_addr),
		.dev_wdata(dev_wdata),
		.dev_wr(dev_wr),
		.dev_rd(dev_rd),
		.dev_rdata(dev_rdata)
	);

endmodule : tcg_host_ctrl

/* File: hw/tcg_pkg.sv */
// tcg_pkg: device map, field layout, host register map and timing for the timer/carrier host
package tcg_pkg;

	// --------------------
	// device register addresses
	// --------------------
	localparam logic [15:0] DEV_PORT3_DIR = 16'hFF23;
	localparam logic [15:0] DEV_CARRIER_CTRL = 16'hFF4F;
	localparam logic [15:0] DEV_TIMER_B_MODE = 16'hFF4E;
	localparam logic [15:0] DEV_TIMER_A_MODE = 16'hFF4C;
	localparam logic [15:0] DEV_PORT3_LATCH = 16'hFF03;
	localparam logic [15:0] DEV_TIMER_A_COMPARE = 16'hFF16;
	localparam logic [15:0] DEV_TIMER_A_COUNTER = 16'hFF17;
	localparam logic [15:0] DEV_TIMER_B_COMPARE = 16'hFF1A;
	localparam logic [15:0] DEV_TIMER_B_HIGH_COMPARE = 16'hFF1B;

	// --------------------
	// device reset values and field positions
	// --------------------
	localparam logic [7:0] PORT3_DIR_RST = 8'hFF;
	localparam logic [7:0] CARRIER_CTRL_RST = 8'h00;
	localparam logic [7:0] PORT3_LATCH_CLEAR = 8'h00;
	localparam logic [7:0] MODE_STOPPED = 8'h00;
	localparam int MODE_RUN_BIT = 7;
	localparam int MODE_CLK_LSB = 3;
	localparam int MODE_SEL_LSB = 1;
	localparam int MODE_OE_BIT = 0;
	localparam logic [1:0] MODE_DISCRETE = 2'h0;
	localparam logic [1:0] MODE_B_CARRIER = 2'h3;
	localparam logic [2:0] CLK_SEL_MAX = 3'h5;
	localparam logic [2:0] CLK_B_EXT_MIN = 3'h2;
	localparam int CAR_CUR_BIT = 0;
	localparam int CAR_NEXT_BIT = 1;
	localparam int CAR_LEVEL_BIT = 2;
	localparam int PIN_EVENT_IN = 1;
	localparam int PIN_TB_OUT = 2;

	// --------------------
	// host register map
	// --------------------
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_CLK_A = 4'h1;
	localparam logic [3:0] REG_CLK_B = 4'h2;
	localparam logic [3:0] REG_CMP_A = 4'h3;
	localparam logic [3:0] REG_CMP_B = 4'h4;
	localparam logic [3:0] REG_CMP_BH = 4'h5;
	localparam logic [3:0] REG_CARRIER = 4'h6;
	localparam logic [3:0] REG_STATUS = 4'h7;
	localparam logic [3:0] REG_GUARD_LO = 4'h8;
	localparam logic [3:0] REG_GUARD_HI = 4'h9;
	localparam logic [3:0] REG_PORT3 = 4'hA;
	localparam int ST_BUSY = 0;
	localparam int ST_CFG_ERR = 1;
	localparam int ST_OVERRUN = 2;
	localparam int ST_CARRIER_ON = 3;
	localparam int ST_IRQ_A = 4;
	localparam int ST_REWRITE = 5;

	// command codes written to REG_CMD
	localparam logic [3:0] OP_STOP_A = 4'h1;
	localparam logic [3:0] OP_STOP_B = 4'h2;
	localparam logic [3:0] OP_INTERVAL_A = 4'h3;
	localparam logic [3:0] OP_INTERVAL_B = 4'h4;
	localparam logic [3:0] OP_EVENT_B = 4'h5;
	localparam logic [3:0] OP_CARRIER_START = 4'h6;
	localparam logic [3:0] OP_CARRIER_NEXT = 4'h7;
	localparam logic [3:0] OP_CARRIER_STOP = 4'h8;

	// --------------------
	// timing
	// --------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int GUARD_HALF_NS = 12800;
	localparam logic [15:0] GUARD_WAIT_CYC =
		16'((GUARD_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
	localparam int RD_LAT = 3;

	// --------------------
	// carriers
	// --------------------
	typedef enum logic [1:0] {STEP_END, STEP_WR, STEP_WR_GUARD} tcg_step_kind_t;
	typedef struct packed {
		tcg_step_kind_t kind;
		logic [15:0] addr;
		logic [7:0] data;
	} tcg_step_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] data;
	} tcg_dev_req_t;

endpackage : tcg_pkg

/* File: hw/tcg_sync2.sv */
// tcg_sync2: two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module tcg_sync2 import tcg_pkg::*; #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// asynchronous in, synchronous out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule : tcg_sync2
